// ==== src/tfa_pkg.sv ====
package tfa_pkg;

    // Register bus geometry
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;

    // Register word addresses
    localparam logic [3:0] ADDR_CTRL    = 4'h0;
    localparam logic [3:0] ADDR_FAR     = 4'h1;
    localparam logic [3:0] ADDR_CONN    = 4'h2;
    localparam logic [3:0] ADDR_IRQ_STS = 4'h3;
    localparam logic [3:0] ADDR_IRQ_MSK = 4'h4;
    localparam logic [3:0] ADDR_OFS_LO  = 4'h8;

    // Control register fields
    localparam int unsigned CTRL_GCI_BIT   = 0;
    localparam int unsigned CTRL_START_BIT = 4;

    // Interrupt status fields
    localparam int unsigned IRQ_W          = 2;
    localparam int unsigned IRQ_DONE_BIT   = 0;
    localparam int unsigned IRQ_FRAME_BIT  = 1;

    // Stream and offset geometry
    localparam int unsigned N_STREAMS   = 32;
    localparam int unsigned N_OFS_REGS  = 8;
    localparam int unsigned NIB_W       = 4;
    localparam int unsigned STR_PER_REG = 4;
    localparam int unsigned DELAY_W     = 12;

    // Reset word and counter step and limit constants
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [11:0] CNT_ONE  = 12'h001;
    localparam logic [3:0]  HC_ONE   = 4'h1;
    localparam logic [3:0]  HC_LAST  = 4'hF;

    // Connection memory word layout
    typedef struct packed {
        logic [1:0] switch_mode_sel;
        logic [4:0] source_stream_num;
        logic [8:0] source_channel_num;
    } tfa_conn_word_type;

    // Frame alignment status layout
    typedef struct packed {
        logic [1:0]  unused;
        logic        eval_complete_flag;
        logic        edge_phase_bit;
        logic [11:0] measured_delay;
    } tfa_far_type;

    // Switching modes
    typedef enum logic [1:0] {
        TFA_MODE_VARIABLE  = 2'h0,
        TFA_MODE_CONSTANT  = 2'h1,
        TFA_MODE_PROCESSOR = 2'h2,
        TFA_MODE_RESERVED  = 2'h3
    } tfa_mode_type;

    // Evaluation states, Gray along idle-armed-done
    typedef enum logic [1:0] {
        TFA_ST_IDLE  = 2'b00,
        TFA_ST_ARMED = 2'b01,
        TFA_ST_DONE  = 2'b11
    } tfa_state_type;

endpackage : tfa_pkg

// ==== src/tfa_frame_align.sv ====
`timescale 1ns/1ps
module tfa_frame_align (
    input  wire logic                        clk_i,
    input  wire logic                        srst_i,
    input  wire logic [tfa_pkg::ADDR_W-1:0]  addr_i,
    input  wire logic [tfa_pkg::DATA_W-1:0]  wdata_i,
    input  wire logic                        wr_i,
    input  wire logic                        rd_i,
    output logic      [tfa_pkg::DATA_W-1:0]  rdata_o,
    output logic                             irq_o,
    input  wire logic                        main_clock_in_i,
    input  wire logic                        frame_pulse_in_i,
    output logic      [tfa_pkg::N_STREAMS-1:0] stream_frame_start_o,
    output logic      [1:0]                  switch_mode_sel_o,
    output logic      [4:0]                  source_stream_num_o,
    output logic      [8:0]                  source_channel_num_o
);

    // Pick the offset nibble of one stream from the offset bank
    function automatic logic [3:0] stream_nibble(input logic [15:0] word, input int unsigned sidx);
        logic [1:0] lane;
        lane = sidx[1:0];
        stream_nibble = word[lane*tfa_pkg::NIB_W +: tfa_pkg::NIB_W];
    endfunction : stream_nibble

    // Detect an edge of chosen direction between two samples
    function automatic logic edge_of(input logic now_v, input logic old_v, input logic rising);
        edge_of = rising ? (now_v & ~old_v) : (~now_v & old_v);
    endfunction : edge_of

    // Registers
    logic [15:0]                 ctrl_q;
    tfa_pkg::tfa_far_type        far_q;
    tfa_pkg::tfa_conn_word_type  conn_q;
    logic [tfa_pkg::IRQ_W-1:0]   irq_sts_q;
    logic [tfa_pkg::IRQ_W-1:0]   irq_msk_q;
    logic [15:0]                 ofs_q [0:tfa_pkg::N_OFS_REGS-1];
    logic [15:0]                 rdata_q;
    logic                        irq_q;
    logic                        start_prev_q;
    tfa_pkg::tfa_state_type      state_q;

    // Pin synchronisers; stage zero is read only by stage one
    logic [1:0]                  mclk_sync_q;
    logic [1:0]                  fp_sync_q;
    logic                        mclk_prev_q;
    logic                        fp_prev_q;

    // Measurement and offset timing
    logic [11:0]                 cyc_cnt_q;
    logic [3:0]                  hc_cnt_q;
    logic                        hc_run_q;
    logic                        hc_new_q;
    logic [tfa_pkg::N_STREAMS-1:0] start_q;

    // Decode of bus strobes
    wire        wr_ctrl   = wr_i && (addr_i == tfa_pkg::ADDR_CTRL);
    wire        wr_conn   = wr_i && (addr_i == tfa_pkg::ADDR_CONN);
    wire        wr_sts    = wr_i && (addr_i == tfa_pkg::ADDR_IRQ_STS);
    wire        wr_msk    = wr_i && (addr_i == tfa_pkg::ADDR_IRQ_MSK);
    wire        ofs_sel   = addr_i[3];
    wire [2:0]  ofs_idx   = addr_i[2:0];

    // Control bits and their edges
    wire        gci_mode  = ctrl_q[tfa_pkg::CTRL_GCI_BIT];
    wire        start_bit = ctrl_q[tfa_pkg::CTRL_START_BIT];
    wire        start_rise = start_bit && !start_prev_q;
    wire        start_fall = !start_bit && start_prev_q;

    // Synchronised pin levels and their edges
    wire        mclk_lvl  = mclk_sync_q[1];
    wire        fp_lvl    = fp_sync_q[1];
    wire        mclk_rise = edge_of(mclk_lvl, mclk_prev_q, 1'b1);
    wire        mclk_any  = mclk_lvl ^ mclk_prev_q;
    // Falling frame edge by default, rising in GCI mode
    wire        fr_edge   = edge_of(fp_lvl, fp_prev_q, gci_mode);
    wire        measure   = (state_q == tfa_pkg::TFA_ST_ARMED) && fr_edge;

    // Interrupt events
    wire [tfa_pkg::IRQ_W-1:0] irq_evt = {fr_edge, measure};

    // Read mux; unmapped words read as zero
    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = tfa_pkg::RST_WORD;
        if (ofs_sel) begin
            rd_mux = ofs_q[ofs_idx];
        end else begin
            case (addr_i)
                tfa_pkg::ADDR_CTRL:    rd_mux = ctrl_q;
                tfa_pkg::ADDR_FAR:     rd_mux = far_q;
                tfa_pkg::ADDR_CONN:    rd_mux = conn_q;
                tfa_pkg::ADDR_IRQ_STS: rd_mux = {14'h0000, irq_sts_q};
                tfa_pkg::ADDR_IRQ_MSK: rd_mux = {14'h0000, irq_msk_q};
                default:               rd_mux = tfa_pkg::RST_WORD;
            endcase
        end
    end

    // Read data stand for exactly one cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_q <= tfa_pkg::RST_WORD;
        end else begin
            rdata_q <= rd_i ? rd_mux : tfa_pkg::RST_WORD;
        end
    end

    // Control and connection word registers
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ctrl_q       <= tfa_pkg::RST_WORD;
            conn_q       <= tfa_pkg::RST_WORD;
            start_prev_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= wdata_i;
            end
            if (wr_conn) begin
                conn_q <= wdata_i;
            end
            start_prev_q <= start_bit;
        end
    end

    // Offset bank, cleared to no shift at reset
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            for (int i = 0; i < tfa_pkg::N_OFS_REGS; i++) begin
                ofs_q[i] <= tfa_pkg::RST_WORD;
            end
        end else if (wr_i && ofs_sel) begin
            ofs_q[ofs_idx] <= wdata_i;
        end
    end

    // Sticky interrupt status; a new event beats a same-cycle clear
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            irq_sts_q <= '0;
            irq_msk_q <= '0;
            irq_q     <= 1'b0;
        end else begin
            irq_sts_q <= (irq_sts_q & ~(wr_sts ? wdata_i[tfa_pkg::IRQ_W-1:0] : '0)) | irq_evt;
            if (wr_msk) begin
                irq_msk_q <= wdata_i[tfa_pkg::IRQ_W-1:0];
            end
            irq_q <= |(irq_sts_q & irq_msk_q);
        end
    end

    // Pin synchronisers and edge history
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            mclk_sync_q <= 2'h0;
            fp_sync_q   <= 2'h0;
            mclk_prev_q <= 1'b0;
            fp_prev_q   <= 1'b0;
        end else begin
            mclk_sync_q <= {mclk_sync_q[0], main_clock_in_i};
            fp_sync_q   <= {fp_sync_q[0], frame_pulse_in_i};
            mclk_prev_q <= mclk_lvl;
            fp_prev_q   <= fp_lvl;
        end
    end

    // Free-running main clock cycle count; the measured delay is read from it
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cyc_cnt_q <= '0;
        end else if (mclk_rise) begin
            cyc_cnt_q <= cyc_cnt_q + tfa_pkg::CNT_ONE;
        end
    end

    // Evaluation sequencer
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_q <= tfa_pkg::TFA_ST_IDLE;
        end else begin
            case (state_q)
                tfa_pkg::TFA_ST_IDLE:  if (start_rise) state_q <= tfa_pkg::TFA_ST_ARMED;
                tfa_pkg::TFA_ST_ARMED: if (start_fall) state_q <= tfa_pkg::TFA_ST_IDLE;
                                       else if (measure) state_q <= tfa_pkg::TFA_ST_DONE;
                tfa_pkg::TFA_ST_DONE:  if (start_fall) state_q <= tfa_pkg::TFA_ST_IDLE;
                default:               state_q <= tfa_pkg::TFA_ST_IDLE;
            endcase
        end
    end

    // Alignment status; the top bits are only ever loaded with zero
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            far_q <= tfa_pkg::RST_WORD;
        end else if (start_fall) begin
            far_q <= tfa_pkg::RST_WORD;
        end else if (measure) begin
            far_q.eval_complete_flag <= 1'b1;
            far_q.edge_phase_bit     <= mclk_lvl;
            far_q.measured_delay     <= cyc_cnt_q;
        end
    end

    // Half-period counter after each frame edge; it stops at its top count
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            hc_cnt_q <= '0;
            hc_run_q <= 1'b0;
            hc_new_q <= 1'b0;
        end else if (fr_edge) begin
            hc_cnt_q <= '0;
            hc_run_q <= 1'b1;
            hc_new_q <= 1'b1;
        end else if (hc_run_q && mclk_any) begin
            hc_cnt_q <= hc_cnt_q + tfa_pkg::HC_ONE;
            hc_run_q <= (hc_cnt_q != (tfa_pkg::HC_LAST - tfa_pkg::HC_ONE));
            hc_new_q <= 1'b1;
        end else begin
            hc_new_q <= 1'b0;
        end
    end

    // Per-stream bit-0 strobe when the half-period count meets its nibble
    for (genvar s = 0; s < tfa_pkg::N_STREAMS; s++) begin : g_stream
        wire [3:0] nib = stream_nibble(ofs_q[s / tfa_pkg::STR_PER_REG], s);
        always_ff @(posedge clk_i) begin
            if (srst_i) begin
                start_q[s] <= 1'b0;
            end else begin
                start_q[s] <= hc_new_q && (hc_cnt_q == nib);
            end
        end
    end

    // Outputs straight from flops
    assign rdata_o              = rdata_q;
    assign irq_o                = irq_q;
    assign stream_frame_start_o = start_q;
    assign switch_mode_sel_o    = conn_q.switch_mode_sel;
    assign source_stream_num_o  = conn_q.source_stream_num;
    assign source_channel_num_o = conn_q.source_channel_num;

    // Checks
    AST_FAR_TOP_ZERO: assert property (@(posedge clk_i) disable iff (srst_i)
        far_q.unused == 2'h0) else $error("status top bits not zero");
    AST_DONE_ON_EDGE: assert property (@(posedge clk_i) disable iff (srst_i)
        (state_q == tfa_pkg::TFA_ST_ARMED && fr_edge && start_bit) |=> far_q.eval_complete_flag)
        else $error("complete flag missed");
    AST_CLEAR_ON_FALL: assert property (@(posedge clk_i) disable iff (srst_i)
        $fell(start_bit) ##1 1'b1 |=> far_q[13:0] == 14'h0000)
        else $error("status not cleared on start fall");
    AST_EDGE_DIR: assert property (@(posedge clk_i) disable iff (srst_i)
        fr_edge |-> (fp_lvl == gci_mode)) else $error("wrong frame edge direction");
    AST_PHASE: assert property (@(posedge clk_i) disable iff (srst_i)
        (measure && !start_fall) |=> far_q.edge_phase_bit == $past(mclk_lvl))
        else $error("phase bit wrong");
    AST_DELAY: assert property (@(posedge clk_i) disable iff (srst_i)
        (measure && !start_fall) |=> far_q.measured_delay == $past(cyc_cnt_q))
        else $error("measured delay wrong");
    AST_NO_REMEASURE: assert property (@(posedge clk_i) disable iff (srst_i)
        (far_q.eval_complete_flag && !start_fall) |=> $stable(far_q.measured_delay))
        else $error("delay changed after completion");
    AST_ZERO_OFFSET: assert property (@(posedge clk_i) disable iff (srst_i)
        (fr_edge && ofs_q[0][3:0] == 4'h0) |=> ##1 start_q[0])
        else $error("stream 0 strobe missing at zero offset");
    AST_MODE_FIELD: assert property (@(posedge clk_i) disable iff (srst_i)
        wr_conn |=> switch_mode_sel_o == $past(wdata_i[15:14]))
        else $error("mode field not taken");
    AST_IRQ_LEVEL: assert property (@(posedge clk_i) disable iff (srst_i)
        ##1 irq_o == $past(|(irq_sts_q & irq_msk_q))) else $error("irq level wrong");

    // Read port: data only in the cycle after the strobe, zero otherwise
    AST_RDATA_IDLE: assert property (@(posedge clk_i) disable iff (srst_i)
        !$past(rd_i) |-> rdata_o == tfa_pkg::RST_WORD)
        else $error("read data not zero outside read cycle");
    AST_RDATA_FAR: assert property (@(posedge clk_i) disable iff (srst_i)
        (rd_i && addr_i == tfa_pkg::ADDR_FAR) |=> rdata_o == $past(far_q))
        else $error("status read data wrong");
    AST_RDATA_CONN: assert property (@(posedge clk_i) disable iff (srst_i)
        (rd_i && addr_i == tfa_pkg::ADDR_CONN) |=> rdata_o == $past(conn_q))
        else $error("connection word read data wrong");
    AST_RDATA_OFS: assert property (@(posedge clk_i) disable iff (srst_i)
        (rd_i && ofs_sel) |=> rdata_o == $past(ofs_q[ofs_idx]))
        else $error("offset read data wrong");

    // Status word is read only; software writes never reach it
    AST_FAR_RO: assert property (@(posedge clk_i) disable iff (srst_i)
        (wr_i && addr_i == tfa_pkg::ADDR_FAR && !measure && !start_fall) |=> $stable(far_q))
        else $error("status changed by a write");

    // Connection word fields land where the switch fabric expects them
    AST_CONN_STREAM: assert property (@(posedge clk_i) disable iff (srst_i)
        wr_conn |=> source_stream_num_o == $past(wdata_i[13:9]))
        else $error("stream field not taken");
    AST_CONN_CHANNEL: assert property (@(posedge clk_i) disable iff (srst_i)
        wr_conn |=> source_channel_num_o == $past(wdata_i[8:0]))
        else $error("channel field not taken");
    AST_CONN_HOLD: assert property (@(posedge clk_i) disable iff (srst_i)
        !wr_conn |=> $stable(conn_q))
        else $error("connection word changed without a write");

    // Offset bank takes whole words and keeps them otherwise
    AST_OFS_WRITE: assert property (@(posedge clk_i) disable iff (srst_i)
        (wr_i && ofs_sel) |=> ofs_q[$past(ofs_idx)] == $past(wdata_i))
        else $error("offset word not taken");
    AST_OFS_HOLD0: assert property (@(posedge clk_i) disable iff (srst_i)
        !(wr_i && ofs_sel && ofs_idx == 3'h0) |=> $stable(ofs_q[0]))
        else $error("offset word 0 changed without a write");

    // Sequencer: arms only on a rising start bit, stops once complete
    AST_STATE_LEGAL: assert property (@(posedge clk_i) disable iff (srst_i)
        state_q inside {tfa_pkg::TFA_ST_IDLE, tfa_pkg::TFA_ST_ARMED, tfa_pkg::TFA_ST_DONE})
        else $error("illegal evaluation state");
    AST_IDLE_STAYS: assert property (@(posedge clk_i) disable iff (srst_i)
        (state_q == tfa_pkg::TFA_ST_IDLE && !start_rise) |=> state_q == tfa_pkg::TFA_ST_IDLE)
        else $error("left idle without a start");
    AST_ARM_ON_RISE: assert property (@(posedge clk_i) disable iff (srst_i)
        (state_q == tfa_pkg::TFA_ST_IDLE && start_rise) |=> state_q == tfa_pkg::TFA_ST_ARMED)
        else $error("start rise did not arm");
    AST_DONE_STATE: assert property (@(posedge clk_i) disable iff (srst_i)
        (measure && !start_fall) |=> state_q == tfa_pkg::TFA_ST_DONE)
        else $error("measurement did not complete");
    AST_DONE_FLAG_HOLD: assert property (@(posedge clk_i) disable iff (srst_i)
        (state_q == tfa_pkg::TFA_ST_DONE && !start_fall) |=> far_q.eval_complete_flag)
        else $error("complete flag dropped while done");
    AST_IDLE_FLAG_CLEAR: assert property (@(posedge clk_i) disable iff (srst_i)
        state_q == tfa_pkg::TFA_ST_IDLE |-> !far_q.eval_complete_flag)
        else $error("complete flag set while idle");

    // Delay reference counter moves once per main clock rise
    AST_CNT_STEP: assert property (@(posedge clk_i) disable iff (srst_i)
        mclk_rise |=> cyc_cnt_q == $past(cyc_cnt_q) + tfa_pkg::CNT_ONE)
        else $error("cycle count did not step");
    AST_CNT_HOLD: assert property (@(posedge clk_i) disable iff (srst_i)
        !mclk_rise |=> $stable(cyc_cnt_q))
        else $error("cycle count moved without a rise");

    // Half-period counter restarts on a frame edge and parks at its top
    AST_HC_RESTART: assert property (@(posedge clk_i) disable iff (srst_i)
        fr_edge |=> (hc_cnt_q == 4'h0) && hc_run_q)
        else $error("half count not restarted");
    AST_HC_TOP: assert property (@(posedge clk_i) disable iff (srst_i)
        hc_cnt_q == tfa_pkg::HC_LAST |-> !hc_run_q)
        else $error("half count ran past its top");
    AST_HC_STEP: assert property (@(posedge clk_i) disable iff (srst_i)
        (hc_run_q && mclk_any && !fr_edge) |=> hc_cnt_q == $past(hc_cnt_q) + tfa_pkg::HC_ONE)
        else $error("half count did not step");

    // Sticky status: set wins, a written one clears, mask taken whole
    AST_IRQ_SET: assert property (@(posedge clk_i) disable iff (srst_i)
        irq_evt[tfa_pkg::IRQ_DONE_BIT] |=> irq_sts_q[tfa_pkg::IRQ_DONE_BIT])
        else $error("done status not set");
    AST_IRQ_CLEAR: assert property (@(posedge clk_i) disable iff (srst_i)
        (wr_sts && wdata_i[0] && !irq_evt[0]) |=> !irq_sts_q[0])
        else $error("done status not cleared");
    AST_MSK_WRITE: assert property (@(posedge clk_i) disable iff (srst_i)
        wr_msk |=> irq_msk_q == $past(wdata_i[1:0]))
        else $error("mask not taken");

endmodule : tfa_frame_align

// ==== bench/tfa_pins_model.sv ====
`timescale 1ns/1ps
// Far side: a slow main clock pin and an on-demand frame pulse pin
module tfa_pins_model (
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        fire_i,
    input  wire logic        want_high_i,
    input  wire logic        gci_i,
    output logic             main_clock_o,
    output logic             frame_o,
    output logic             lvl_o,
    output logic [11:0]      cnt_o
);
    logic [2:0]  div_q;
    logic [11:0] rise_q;
    logic [7:0]  len_q;
    logic        arm_q;
    logic        act_q;

    // Pin idles at the level opposite its active edge
    assign frame_o = act_q ? gci_i : ~gci_i;

    // Edge is placed mid phase so the pin never moves next to a clock edge
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            div_q        <= 3'h0;
            main_clock_o <= 1'b0;
            rise_q       <= 12'h000;
            arm_q        <= 1'b0;
            act_q        <= 1'b0;
            len_q        <= 8'h00;
            cnt_o        <= 12'h000;
            lvl_o        <= 1'b0;
        end else begin
            div_q <= div_q + 3'h1;
            if (div_q == 3'h7) begin
                main_clock_o <= ~main_clock_o;
                if (!main_clock_o) rise_q <= rise_q + 12'h001;
            end
            if (fire_i) arm_q <= 1'b1;
            if (arm_q && main_clock_o == want_high_i && div_q == 3'h3) begin
                arm_q <= 1'b0;
                act_q <= 1'b1;
                len_q <= 8'hA0;
                cnt_o <= rise_q;
                lvl_o <= main_clock_o;
            end else if (len_q != 8'h00) begin
                len_q <= len_q - 8'h01;
                if (len_q == 8'h01) act_q <= 1'b0;
            end
        end
    end
endmodule : tfa_pins_model

// ==== bench/tfa_frame_align_tb.sv ====
`timescale 1ns/1ps
module tfa_frame_align_tb;
    logic        clk_i   = 1'b0;
    logic        srst_i  = 1'b1;
    logic [3:0]  addr_i  = 4'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic        wr_i    = 1'b0;
    logic        rd_i    = 1'b0;
    logic        fire    = 1'b0;
    logic        want_hi = 1'b0;
    logic        gci     = 1'b0;
    logic [15:0] rdata_o, rv;
    logic [31:0] sfs;
    logic [11:0] m_cnt;
    logic [8:0]  cnum;
    logic [4:0]  snum;
    logic [1:0]  msel;
    logic        irq_o, mclk, fpin, m_lvl;
    int          err_total = 0;
    int          n_tests   = 0;
    int          cyc       = 0;
    int          t_p[32];

    tfa_frame_align dut (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .main_clock_in_i(mclk),
        .frame_pulse_in_i(fpin), .stream_frame_start_o(sfs), .switch_mode_sel_o(msel),
        .source_stream_num_o(snum), .source_channel_num_o(cnum));
    tfa_pins_model pins (.clk_i(clk_i), .srst_i(srst_i), .fire_i(fire), .want_high_i(want_hi),
        .gci_i(gci), .main_clock_o(mclk), .frame_o(fpin), .lvl_o(m_lvl), .cnt_o(m_cnt));

    initial forever #2 clk_i = ~clk_i;

    // First strobe cycle per stream; later edges of the same pulse are ignored
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        for (int i = 0; i < 32; i++) if (sfs[i] === 1'b1 && t_p[i] < 0) t_p[i] = cyc;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask : rd

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    // Reset values, refused write to status, unmapped read
    task automatic t_reset;
        rd(tfa_pkg::ADDR_FAR, rv); chk("status", 16'h0000, rv);
        for (int k = 0; k < 8; k++) begin
            rd(tfa_pkg::ADDR_OFS_LO + 4'(k), rv); chk("offset rst", 16'h0000, rv);
        end
        wr(tfa_pkg::ADDR_FAR, 16'hFFFF);
        rd(tfa_pkg::ADDR_FAR, rv); chk("status ro", 16'h0000, rv);
        rd(4'h5, rv); chk("unmapped", 16'h0000, rv);
        chk("irq_o", 16'h0000, {15'h0, irq_o});
        $display("reset test done");
    endtask : t_reset

    // Every switching mode with distinct stream and channel fields
    task automatic t_conn;
        logic [15:0] w;
        for (int m = 0; m < 4; m++) begin
            w = {2'(m), 5'h15 ^ 5'(m), 9'h1A5 ^ 9'(m << 7)};
            wr(tfa_pkg::ADDR_CONN, w); tick(1);
            chk("mode", {14'h0, w[15:14]}, {14'h0, msel});
            chk("stream", {11'h0, w[13:9]}, {11'h0, snum});
            chk("channel", {7'h00, w[8:0]}, {7'h00, cnum});
            rd(tfa_pkg::ADDR_CONN, rv); chk("conn rd", w, rv);
        end
        $display("conn test done");
    endtask : t_conn

    // One evaluation: arm, edge in chosen clock phase, readout, clear
    task automatic t_eval(input logic g, input logic hi);
        gci <= g;
        wr(tfa_pkg::ADDR_IRQ_MSK, 16'h0001);
        wr(tfa_pkg::ADDR_CTRL, {11'h0, 1'b1, 3'h0, g});
        tick(4);
        want_hi <= hi;
        fire    <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
        for (int i = 0; i < 100 && irq_o !== 1'b1; i++) tick(1);
        chk("irq_o done", 16'h0001, {15'h0, irq_o});
        rd(tfa_pkg::ADDR_FAR, rv);
        chk("status", {3'b001, hi, m_cnt}, rv);
        wr(tfa_pkg::ADDR_OFS_LO + 4'h7, {12'h000, rv[2:0], ~rv[12]});
        rd(tfa_pkg::ADDR_OFS_LO + 4'h7, rv); chk("ofs7", {12'h000, m_cnt[2:0], ~hi}, rv);
        wr(tfa_pkg::ADDR_IRQ_STS, 16'h0003); tick(2);
        chk("irq_o clr", 16'h0000, {15'h0, irq_o});
        wr(tfa_pkg::ADDR_CTRL, {15'h0, g}); tick(3);
        rd(tfa_pkg::ADDR_FAR, rv); chk("status clr", 16'h0000, rv);
        tick(200);
        $display("eval test done");
    endtask : t_eval

    // Stream strobes: half steps of 8 cycles, span from offset 2 to 15 of 6.5 periods, masked irq
    task automatic t_strobe;
        wr(tfa_pkg::ADDR_OFS_LO, 16'h0F20);
        wr(tfa_pkg::ADDR_OFS_LO + 4'h1, 16'h0300);
        rd(tfa_pkg::ADDR_OFS_LO, rv); chk("ofs0", 16'h0F20, rv);
        // Leave GCI mode before the pin idle level flips, so no stray edge starts strobes
        wr(tfa_pkg::ADDR_CTRL, 16'h0000);
        gci <= 1'b0;
        wr(tfa_pkg::ADDR_IRQ_MSK, 16'h0000);
        wr(tfa_pkg::ADDR_IRQ_STS, 16'h0003);
        for (int i = 0; i < 32; i++) t_p[i] = -1;
        fire <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
        tick(200);
        chk("half step", 16'd8, 16'(t_p[6] - t_p[1]));
        chk("full span", 16'd104, 16'(t_p[2] - t_p[1]));
        chk("irq masked", 16'h0000, {15'h0, irq_o});
        rd(tfa_pkg::ADDR_IRQ_STS, rv); chk("irq sts", 16'h0002, rv);
        wr(tfa_pkg::ADDR_IRQ_MSK, 16'h0002); tick(2);
        chk("irq unmasked", 16'h0001, {15'h0, irq_o});
        wr(tfa_pkg::ADDR_IRQ_STS, 16'h0002); tick(2);
        chk("irq cleared", 16'h0000, {15'h0, irq_o});
        $display("strobe test done");
    endtask : t_strobe

    // Watchdog sized well above the whole sequence
    initial begin
        repeat (60000) @(posedge clk_i);
        err_total++;
        end_sim();
    end

    initial begin
        repeat (12) @(posedge clk_i);
        srst_i <= 1'b0;
        t_reset();
        t_conn();
        t_eval(1'b0, 1'b1);
        t_eval(1'b0, 1'b0);
        t_eval(1'b1, 1'b1);
        t_strobe();
        end_sim();
    end
endmodule : tfa_frame_align_tb
